// >>> core/tkc_ctrl.sv
// touch key event and reset control: change line, reset sequence,
// calibration with key autosense, guard keys and detect filtering
// assumes an AXI4-Lite master on aclk and an acquisition front end that
// answers acq_req with one sample_valid pulse carrying deltas and bursts
//
// Summary of operation
// - status byte change pulls change line low
// - status read releases the change line
// - unchanged status: any read releases line
// - bus access wakes device from sleep
// - events only from masked keys, inputs
// - unmasked group key is silent guard
// - guard detect suppresses other group keys
// - optional active-low external reset pin
// - nonzero reset write: watchdog, then reset
// - refuse all accesses during initialization
// - change line asserted after ready wait
// - calibrate, then assert change line again
// - nonzero calibration write recalibrates in run state
// - calibration excludes keys with bad bursts
// - status byte reports enabled key count
// - touch needs delta at or over key threshold
// - integrator counts consecutive hits; fast release
// - no fast start if other key detects
// - out-of-range burst: disabled, signal zero
// - references readable at indices 52 to 63
// - fastest interval while calibrating or integrating
`timescale 1ns/1ns
module tkc_ctrl
    import tkc_pkg::*;
#(
    parameter int P_WDOG_CYC = tkc_pkg::WDOG_CYC,
    parameter int P_INIT_CYC = tkc_pkg::INIT_CYC,
    parameter int P_READY_CYC = tkc_pkg::READY_CYC,
    parameter int P_CYCLE_CYC = tkc_pkg::CYCLE_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // external pins
    input wire logic ext_reset_n,
    input wire logic [tkc_pkg::NIO-1:0] io_in,
    output logic change_notify_n_o,
    output logic change_notify_n_oe_n,
    // acquisition front end
    output logic acq_req,
    input wire logic sample_valid,
    input wire logic [tkc_pkg::NKEY*tkc_pkg::DW-1:0] sample_delta,
    input wire logic [tkc_pkg::NKEY*tkc_pkg::BW-1:0] sample_burst,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tkc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        tkc_state_t st;
        logic [TW-1:0] tmr;
        logic [TW-1:0] cyc;
        logic [7:0] lp_cnt;
        logic acq_req;
        logic [NKEY-1:0] key_mask;
        logic [NKEY-1:0] grp_mask;
        logic [7:0] di_lim;
        logic fast_en;
        logic [7:0] lp_mode;
        logic [NKEY*8-1:0] thr;
        logic [NKEY*16-1:0] refs;
        logic [NKEY*DW-1:0] sig;
        logic [NKEY-1:0] enabled;
        logic [2:0] key_count;
        logic [NKEY-1:0] det;
        logic [NIO-1:0] inp;
        logic [NKEY-1:0] snap_det;
        logic [NIO-1:0] snap_inp;
        logic pending;
        logic aw_have;
        logic [7:0] aw_idx;
        logic w_have;
        logic [7:0] wdata;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tkc_ctrl_t;

    function automatic tkc_ctrl_t reset_state();
        tkc_ctrl_t r;
        r = '0;
        r.st = ST_INIT;
        r.key_mask = KEY_MASK_RST;
        r.grp_mask = GRP_MASK_RST;
        r.di_lim = DI_RST;
        r.lp_mode = LP_RST;
        r.thr = {NKEY{THR_RST}};
        r.awready = 1'b1;
        r.wready = 1'b1;
        r.arready = 1'b1;
        return r;
    endfunction

    tkc_ctrl_t s_r;
    tkc_ctrl_t s_nxt;

    // ****************************************
    // pin synchronisers and key filters
    // ****************************************
    logic ext_reset_n_s;
    logic [NIO-1:0] io_s;
    logic [NKEY-1:0] raw_det;
    logic [NKEY-1:0] busy;
    logic run_sample;

    tkc_sync2 #(.W(1), .INIT(1'b1)) u_sync_rst (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(ext_reset_n),
        .q(ext_reset_n_s)
    );

    tkc_sync2 #(.W(NIO), .INIT('0)) u_sync_io (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(io_in),
        .q(io_s)
    );

    assign run_sample = sample_valid && (s_r.st == ST_RUN);

    genvar gk;
    generate
        for (gk = 0; gk < NKEY; gk++) begin : g_key
            tkc_key_filter u_filt (
                .aclk(aclk),
                .aresetn(aresetn),
                .sample(run_sample),
                .delta(sample_delta[gk*DW +: DW]),
                .thr(s_r.thr[gk*8 +: 8]),
                .di_lim(s_r.di_lim),
                .fast_en(s_r.fast_en),
                .enabled(s_r.enabled[gk]),
                .other_det((raw_det & ~(NKEY'(1) << gk)) != '0),
                .det(raw_det[gk]),
                .busy(busy[gk])
            );
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    logic nack;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] ar_idx;
    logic [NKEY-1:0] guard_keys;
    logic guard_hit;
    logic [NKEY-1:0] det_rep;
    logic ev;
    logic clr;
    logic tick;
    logic [BW-1:0] bl;
    logic [31:0] rd_val;
    logic rd_ok;
    logic [7:0] ri;

    always_comb begin
        s_nxt = s_r;
        s_nxt.acq_req = 1'b0;
        nack = (s_r.st == ST_INIT) || (s_r.st == ST_WDOG);
        ar_idx = s_axi_araddr[9:2];
        rd_val = 32'h0000_0000;
        rd_ok = s_axi_araddr[11:10] == 2'h0;
        ri = 8'h00;
        bl = '0;

        // base cycle divider
        tick = s_r.cyc == TW'(P_CYCLE_CYC - 1);
        s_nxt.cyc = tick ? '0 : s_r.cyc + TW'(1);

        // guard keys are in the group but out of the key mask
        guard_keys = s_r.grp_mask & ~s_r.key_mask & s_r.enabled;
        guard_hit = (raw_det & guard_keys) != '0;
        det_rep = raw_det & s_r.enabled;
        if (guard_hit) begin
            det_rep = det_rep & ~(s_r.grp_mask & ~guard_keys);
        end

        // read decode
        unique case (1'b1)
            ar_idx == IDX_DET: rd_val = 32'(s_r.det);
            ar_idx == IDX_INP: rd_val = 32'(s_r.inp);
            ar_idx == IDX_STAT: rd_val = 32'({s_r.st == ST_CAL, 4'h0, s_r.key_count});
            ar_idx == IDX_CAL: rd_val = 32'h0000_0000;
            ar_idx == IDX_RESET: rd_val = 32'h0000_0000;
            ar_idx == IDX_LP: rd_val = 32'(s_r.lp_mode);
            ar_idx == IDX_KEYMASK: rd_val = 32'(s_r.key_mask);
            ar_idx == IDX_GRPMASK: rd_val = 32'(s_r.grp_mask);
            ar_idx == IDX_DI: rd_val = 32'(s_r.di_lim);
            ar_idx == IDX_CTRL: rd_val = 32'(s_r.fast_en);
            ar_idx >= IDX_THR0 && ar_idx < IDX_THR0 + 8'(NKEY): begin
                ri = ar_idx - IDX_THR0;
                rd_val = 32'(s_r.thr[ri*8 +: 8]);
            end
            ar_idx >= IDX_SIG0 && ar_idx < IDX_SIG0 + 8'(NKEY): begin
                ri = ar_idx - IDX_SIG0;
                rd_val = 32'(s_r.sig[ri*DW +: DW]);
            end
            ar_idx >= IDX_REF0 && ar_idx <= IDX_REF_LAST: begin
                // low byte at even index, high byte at odd index
                ri = ar_idx - IDX_REF0;
                rd_val = 32'(s_r.refs[ri*8 +: 8]);
            end
            default: rd_ok = 1'b0;
        endcase

        // axi write channels
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_idx = (s_axi_awaddr[11:10] == 2'h0) ? s_axi_awaddr[9:2] : 8'hff;
            s_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_have = 1'b1;
            // writable registers are one byte wide; lane 0 alone carries data
            s_nxt.wdata = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            s_nxt.wready = 1'b0;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end
        wr_fire = s_r.aw_have && s_r.w_have && !s_r.bvalid;
        if (wr_fire) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (nack) begin
                s_nxt.bresp = RESP_SLVERR;
            end else begin
                priority case (1'b1)
                    s_r.aw_idx == IDX_LP: s_nxt.lp_mode = s_r.wdata;
                    s_r.aw_idx == IDX_KEYMASK: s_nxt.key_mask = s_r.wdata[NKEY-1:0];
                    s_r.aw_idx == IDX_GRPMASK: s_nxt.grp_mask = s_r.wdata[NKEY-1:0];
                    s_r.aw_idx == IDX_DI: s_nxt.di_lim = s_r.wdata;
                    s_r.aw_idx == IDX_CTRL: s_nxt.fast_en = s_r.wdata[0];
                    s_r.aw_idx == IDX_CAL || s_r.aw_idx == IDX_RESET: begin
                    end
                    s_r.aw_idx >= IDX_THR0 && s_r.aw_idx < IDX_THR0 + 8'(NKEY): begin
                        ri = s_r.aw_idx - IDX_THR0;
                        s_nxt.thr[ri*8 +: 8] = s_r.wdata;
                    end
                    s_r.aw_idx <= IDX_REF_LAST: begin
                    end
                    default: s_nxt.bresp = RESP_SLVERR;
                endcase
            end
        end

        // axi read channel
        rd_fire = s_axi_arvalid && s_r.arready;
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (rd_fire) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = (nack || !rd_ok) ? 32'h0000_0000 : rd_val;
            s_nxt.rresp = (nack || !rd_ok) ? RESP_SLVERR : RESP_OKAY;
        end

        // change line: set wins over clear
        ev = (((det_rep ^ s_r.det) & s_r.key_mask) != '0) || (io_s != s_r.inp);
        s_nxt.det = det_rep;
        s_nxt.inp = io_s;
        clr = rd_fire && !nack && ((ar_idx == IDX_DET) || (ar_idx == IDX_INP)
            || ((s_r.det == s_r.snap_det) && (s_r.inp == s_r.snap_inp)));
        if (clr) begin
            s_nxt.pending = 1'b0;
            s_nxt.snap_det = s_r.det;
            s_nxt.snap_inp = s_r.inp;
        end
        if (ev && s_r.st == ST_RUN) begin
            s_nxt.pending = 1'b1;
        end

        // sequencing
        unique case (s_r.st)
            ST_INIT: begin
                s_nxt.tmr = s_r.tmr + TW'(1);
                if (s_r.tmr == TW'(P_INIT_CYC - 1)) begin
                    s_nxt.st = ST_READY;
                    s_nxt.tmr = '0;
                end
            end
            ST_READY: begin
                s_nxt.tmr = s_r.tmr + TW'(1);
                if (s_r.tmr == TW'(P_READY_CYC - 1)) begin
                    s_nxt.pending = 1'b1;
                    s_nxt.st = ST_CAL;
                    s_nxt.acq_req = 1'b1;
                end
            end
            ST_CAL: begin
                // fastest interval: retry every base cycle until sampled
                s_nxt.acq_req = tick;
                if (sample_valid) begin
                    s_nxt.key_count = '0;
                    for (int k = 0; k < NKEY; k++) begin
                        bl = sample_burst[k*BW +: BW];
                        s_nxt.refs[k*16 +: 16] = 16'(bl);
                        s_nxt.enabled[k] = (bl >= BURST_MIN) && (bl <= BURST_MAX);
                        s_nxt.key_count = s_nxt.key_count + 3'(s_nxt.enabled[k]);
                        s_nxt.sig[k*DW +: DW] = '0;
                    end
                    s_nxt.st = ST_RUN;
                    s_nxt.acq_req = 1'b0;
                    s_nxt.pending = 1'b1;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    s_nxt.lp_cnt = s_r.lp_cnt + 8'h01;
                    if (s_r.lp_mode != LP_SLEEP && ((busy != '0) || s_r.lp_mode == LP_FREE
                        || s_r.lp_cnt + 8'h01 >= s_r.lp_mode)) begin
                        s_nxt.acq_req = 1'b1;
                        s_nxt.lp_cnt = 8'h00;
                    end
                end
                // an access wakes a sleeping device for one acquisition
                if (s_r.lp_mode == LP_SLEEP && (rd_fire || wr_fire)) begin
                    s_nxt.acq_req = 1'b1;
                end
                if (sample_valid) begin
                    for (int k = 0; k < NKEY; k++) begin
                        s_nxt.sig[k*DW +: DW] = s_r.enabled[k] ? sample_delta[k*DW +: DW] : '0;
                    end
                end
                if (wr_fire && s_r.aw_idx == IDX_CAL && s_r.wdata != 8'h00) begin
                    s_nxt.st = ST_CAL;
                    s_nxt.acq_req = 1'b1;
                end
            end
            ST_WDOG: begin
                s_nxt.tmr = s_r.tmr + TW'(1);
                if (s_r.tmr == TW'(P_WDOG_CYC - 1)) begin
                    s_nxt = reset_state();
                end
            end
            default: s_nxt = reset_state();
        endcase

        // soft reset is accepted in the ready, calibration and run states
        if (wr_fire && !nack && s_r.aw_idx == IDX_RESET && s_r.wdata != 8'h00) begin
            s_nxt.st = ST_WDOG;
            s_nxt.tmr = '0;
            s_nxt.acq_req = 1'b0;
        end

        // pin reset holds the device at the start of initialization
        if (!ext_reset_n_s) begin
            s_nxt = reset_state();
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= reset_state();
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // the pin only ever pulls low, so its data level is a constant zero
    assign change_notify_n_o = 1'b0;
    assign change_notify_n_oe_n = !s_r.pending;
    assign acq_req = s_r.acq_req;
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rvalid = s_r.rvalid;
endmodule

// >>> core/tkc_pkg.sv
// package of the touch key event and reset control block
// assumes a 50 MHz aclk; timing counts derive from the figures here
package tkc_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int T_WDOG_US = 16000;
    localparam int T_INIT_US = 30000;
    localparam int T_READY_US = 80000;
    localparam int T_CYCLE_US = 16000;
    localparam int WDOG_CYC = T_WDOG_US * CLK_MHZ;
    localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
    localparam int READY_CYC = T_READY_US * CLK_MHZ;
    localparam int CYCLE_CYC = T_CYCLE_US * CLK_MHZ;
    localparam int TW = 23;

    // ****************************************
    // channel geometry and limits
    // ****************************************
    localparam int NKEY = 6;
    localparam int NIO = 7;
    localparam int DW = 12;
    localparam int BW = 11;
    localparam logic [BW-1:0] BURST_MIN = 11'h010;
    localparam logic [BW-1:0] BURST_MAX = 11'h600;
    localparam logic [7:0] FAST_DI = 8'h02;

    // ****************************************
    // reset values and low power mode codes
    // ****************************************
    localparam logic [7:0] DI_RST = 8'h04;
    localparam logic [7:0] THR_RST = 8'h0a;
    localparam logic [7:0] LP_RST = 8'h02;
    localparam logic [7:0] LP_SLEEP = 8'h00;
    localparam logic [7:0] LP_FREE = 8'hff;
    localparam logic [NKEY-1:0] KEY_MASK_RST = 6'h3f;
    localparam logic [NKEY-1:0] GRP_MASK_RST = 6'h00;

    // ****************************************
    // register word indices (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] IDX_DET = 8'h00;
    localparam logic [7:0] IDX_INP = 8'h01;
    localparam logic [7:0] IDX_STAT = 8'h02;
    localparam logic [7:0] IDX_CAL = 8'h03;
    localparam logic [7:0] IDX_RESET = 8'h04;
    localparam logic [7:0] IDX_LP = 8'h05;
    localparam logic [7:0] IDX_KEYMASK = 8'h06;
    localparam logic [7:0] IDX_GRPMASK = 8'h07;
    localparam logic [7:0] IDX_DI = 8'h08;
    localparam logic [7:0] IDX_CTRL = 8'h09;
    localparam logic [7:0] IDX_THR0 = 8'h0a;
    localparam logic [7:0] IDX_SIG0 = 8'h10;
    localparam logic [7:0] IDX_REF0 = 8'h34;
    localparam logic [7:0] IDX_REF_LAST = 8'h3f;
    localparam int STAT_CAL_BIT = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_WDOG = 3'b001,
        ST_INIT = 3'b010,
        ST_READY = 3'b011,
        ST_CAL = 3'b100
    } tkc_state_t;

endpackage

// >>> core/tkc_sync2.sv
// two flip-flop synchroniser for levels from outside the aclk domain
// assumes each bit is an independent slow level
`timescale 1ns/1ns
module tkc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } tkc_sync_t;

    tkc_sync_t s_r;
    tkc_sync_t s_nxt;

    always_comb begin
        s_nxt.meta = d;
        s_nxt.q = s_r.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= {INIT, INIT};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;
endmodule

// >>> core/tkc_key_filter.sv
// detect integrator of one key channel
// assumes sample is a one-cycle pulse carrying a fresh delta
`timescale 1ns/1ns
module tkc_key_filter
    import tkc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sample and settings
    input wire logic sample,
    input wire logic [tkc_pkg::DW-1:0] delta,
    input wire logic [7:0] thr,
    input wire logic [7:0] di_lim,
    input wire logic fast_en,
    input wire logic enabled,
    input wire logic other_det,
    // result
    output logic det,
    output logic busy
);
    typedef struct packed {
        logic det;
        logic [7:0] cnt;
    } tkc_filt_t;

    tkc_filt_t s_r;
    tkc_filt_t s_nxt;
    logic hit;
    logic [7:0] lim;
    logic [7:0] need_on;
    logic [7:0] need_off;
    logic [7:0] cnt_inc;

    always_comb begin
        s_nxt = s_r;
        hit = delta >= DW'(thr);
        lim = (di_lim == 8'h00) ? 8'h01 : di_lim;
        // fast start only while no other key is in detect
        need_on = (fast_en && !other_det) ? FAST_DI : lim;
        need_off = fast_en ? FAST_DI : lim;
        cnt_inc = s_r.cnt + 8'h01;
        if (!enabled) begin
            s_nxt.det = 1'b0;
            s_nxt.cnt = 8'h00;
        end else if (sample) begin
            if (!s_r.det) begin
                if (hit) begin
                    s_nxt.cnt = cnt_inc;
                    if (cnt_inc >= need_on) begin
                        s_nxt.det = 1'b1;
                        s_nxt.cnt = 8'h00;
                    end
                end else begin
                    s_nxt.cnt = 8'h00;
                end
            end else begin
                if (!hit) begin
                    s_nxt.cnt = cnt_inc;
                    if (cnt_inc >= need_off) begin
                        s_nxt.det = 1'b0;
                        s_nxt.cnt = 8'h00;
                    end
                end else begin
                    s_nxt.cnt = 8'h00;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign det = s_r.det;
    assign busy = s_r.cnt != 8'h00;
endmodule

// >>> tb/tkc_ctrl_assertions.sv
// port checker of tkc_ctrl, bound into every instance below
// assumes one aclk domain with synchronous aresetn
`timescale 1ns/1ns
module tkc_ctrl_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n,
    // change line
    input wire logic change_notify_n_o,
    input wire logic change_notify_n_oe_n,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    line_low_a: assert property (change_notify_n_o == 1'b0)
        else $error("line data");
    // clear lands the cycle after the read address is accepted
    line_hold_a: assert property (ext_reset_n && !change_notify_n_oe_n && !s_axi_arvalid && !s_axi_rvalid &&
        !$past(s_axi_rvalid) |=> !change_notify_n_oe_n) else $error("line dropped");
    rst_line_a: assert property ($rose(aresetn) |-> change_notify_n_oe_n [*8])
        else $error("line after reset");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read hold");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write hold");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("aw ready");
endmodule
bind tkc_ctrl tkc_ctrl_chk chk (.*);

// >>> tb/tkc_acq_model.sv
// acquisition front end: one sample lat cycles after each request
// assumes the bench sets deltas, bursts and lat
`timescale 1ns/1ns
module tkc_acq_model (
    // clock and request
    input wire logic aclk,
    input wire logic acq_req,
    // bench controls
    input wire logic [3:0] lat,
    input wire logic [71:0] dlt,
    input wire logic [65:0] bst,
    // sample
    output logic sample_valid,
    output logic [71:0] sample_delta,
    output logic [65:0] sample_burst
);
    int cnt = 0;
    // inverted junk outside the pulse, so stale data never passes
    always @(posedge aclk) begin
        sample_valid <= 1'b0;
        sample_delta <= ~dlt;
        sample_burst <= ~bst;
        if (acq_req) begin
            cnt <= lat;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                sample_valid <= 1'b1;
                sample_delta <= dlt;
                sample_burst <= bst;
            end
        end
    end
endmodule

// >>> tb/test_tkc_ctrl.sv
// bench of tkc_ctrl with the front end model
// assumes shortened timing parameters
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t bad %h", $time, a); end end
module test_tkc_ctrl;
    import tkc_pkg::*;
    logic aclk = 0, aresetn = 0, ext_reset_n = 1, change_notify_n_o, change_notify_n_oe_n, acq_req, sample_valid;
    logic [6:0] io_in = '0;
    logic [71:0] sample_delta, dlt = '0;
    logic [65:0] sample_burst, bst = {11'h00f, 11'h601, 11'h600, 11'h010, 11'h600, 11'h010};
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1, lat = 4'h3;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int error_cnt = 0, checks = 0, cyc = 0;
    always #10 aclk = ~aclk;
    tkc_ctrl #(.P_WDOG_CYC(20), .P_INIT_CYC(30), .P_READY_CYC(40), .P_CYCLE_CYC(10)) uut (.*);
    tkc_acq_model fe (.*);
    // ****************
    // bus and line tasks
    // ****************
    task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            a |= s_axi_awready;
            w |= s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= !a;
            s_axi_wvalid <= !w;
        end while (!(a && w));
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        `CHK(s_axi_bresp, RESP_OKAY)
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic wline(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (change_notify_n_oe_n !== v && n < 400);
        `CHK(change_notify_n_oe_n, v)
        @(posedge aclk);
    endtask
    task automatic t_start;
        rd(8'h00, 32'h0, RESP_SLVERR);
        wline(1'b0);
        rd(8'h00, 32'h0, RESP_OKAY);
        wline(1'b1);
        wline(1'b0);
        rd(8'h02, 32'h4, RESP_OKAY);
        rd(8'h15, 32'h0, RESP_OKAY);
        rd(8'h16, 32'h0, RESP_SLVERR);
    endtask
    task automatic t_touch;
        rd(8'h00, 32'h0, RESP_OKAY);
        wline(1'b1);
        lat <= 4'h1;
        dlt <= 72'h00900a;
        wline(1'b0);
        rd(8'h00, 32'h1, RESP_OKAY);
        wline(1'b1);
        dlt <= 72'h0;
        wline(1'b0);
        dlt <= 72'h00a;
        repeat (80) @(posedge aclk);
        `CHK(change_notify_n_oe_n, 1'b0)
        rd(8'h09, 32'h0, RESP_OKAY);
        wline(1'b1);
        dlt <= 72'h0;
        wline(1'b0);
        rd(8'h00, 32'h0, RESP_OKAY);
        wline(1'b1);
    endtask
    task automatic t_guard;
        wr(8'h06, 8'h3e);
        wr(8'h07, 8'h03);
        dlt <= 72'h00a00a;
        repeat (80) @(posedge aclk);
        `CHK(change_notify_n_oe_n, 1'b1)
        rd(8'h00, 32'h1, RESP_OKAY);
        dlt <= 72'h0;
        repeat (80) @(posedge aclk);
    endtask
    task automatic t_reset;
        wr(8'h03, 8'h01);
        wline(1'b0);
        rd(8'h00, 32'h0, RESP_OKAY);
        wline(1'b1);
        wr(8'h04, 8'h01);
        repeat (25) @(posedge aclk);
        rd(8'h00, 32'h0, RESP_SLVERR);
        wline(1'b0);
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(change_notify_n_oe_n, 1'b1)
        ext_reset_n <= 1'b1;
        wline(1'b0);
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_start();
        t_touch();
        t_guard();
        t_reset();
        tally_and_finish();
    end
endmodule
